// ===== common/eiop_cfg.svh
`ifndef EIOP_CFG_SVH
`define EIOP_CFG_SVH

// ----------------------------------------
// Register byte offsets
// ----------------------------------------
`define EIOP_OFS_OUT_LO 8'h00
`define EIOP_OFS_OUT_HI 8'h04
`define EIOP_OFS_IN_LO 8'h08
`define EIOP_OFS_IN_HI 8'h0c
`define EIOP_OFS_OE_LO 8'h10
`define EIOP_OFS_OE_HI 8'h14
`define EIOP_OFS_ISR_LO 8'h18
`define EIOP_OFS_ISR_HI 8'h1c
`define EIOP_OFS_RISE_LO 8'h20
`define EIOP_OFS_RISE_HI 8'h24
`define EIOP_OFS_FALL_LO 8'h28
`define EIOP_OFS_FALL_HI 8'h2c
`define EIOP_OFS_VERSION 8'hfc

// ----------------------------------------
// Reset values and geometry
// ----------------------------------------
`define EIOP_RST_WORD 32'h0000_0000
`define EIOP_LINES 64
`define EIOP_GROUPS 8
`define EIOP_GROUP_W 8

// ----------------------------------------
// Timing: gap between output groups
// ----------------------------------------
`define EIOP_GAP_NS 15
`define EIOP_CLK_NS 8
`define EIOP_GAP_CYC ((`EIOP_GAP_NS + `EIOP_CLK_NS - 1) / `EIOP_CLK_NS)

`endif

// ===== common/eiop_pkg.sv
package eiop_pkg;

  // Register access request from the bridge's local bus
  typedef struct packed {
    logic wr;
    logic rd;
    logic [7:0] addr;
    logic [31:0] wdata;
  } eiop_req_t;

  // Staggered output update sequencer
  typedef enum logic [0:0] {
    EIOP_IDLE = 1'b0,
    EIOP_RUN = 1'b1
  } eiop_seq_t;

endpackage

// ===== logic/eiop_line_group.sv
`timescale 1ns/1ns
// One group of output lines; latches data and enables on its load strobe
module eiop_line_group #(
  parameter int W = 8
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic ce,
  input wire logic load,
  input wire logic [W-1:0] din,
  input wire logic [W-1:0] oein,
  output logic [W-1:0] dout,
  output logic [W-1:0] oe
);

  // Applied pin state, changed only when this group's turn comes
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      dout <= '0;
      oe <= '0;
    end else if (ce && load) begin
      dout <= din;
      oe <= oein;
    end
  end

endmodule

// ===== logic/eiop_top.sv
`timescale 1ns/1ns
`include "eiop_cfg.svh"
// Summary of operation
// RULE_01: Sixty-four lines, each with a gated output buffer and an always-on input.
// RULE_02: Input path stays live, so input reads show the line even while driven.
// RULE_03: A line is driven only while its enable bit is 1; enables reset to 0.
// RULE_04: Differential build keeps the upper enable word readable and writable, driving nothing.
// RULE_05: Differential build: receivers always on, transmitters gated by their enable bit.
// RULE_06: Differential build offers thirty-two lines.
// RULE_07: Outputs change in eight groups of eight, about 15 ns apart.
// RULE_08: Every write to output or enable registers restarts the staggered update.
// RULE_09: An enabled edge sets the line's status bit; status resets to 0.
// RULE_10: Writing 1 to a status bit clears it; writing 0 leaves it.
// RULE_11: All sixty-four status bits merge onto one local interrupt.
// RULE_12: Local interrupt is active low, held while any status bit is set.
// RULE_13: Differential build reads 0 from upper status and upper input words.
// RULE_14: Rising enable bit lets a low-to-high transition set status; resets to 0.
// RULE_15: Falling enable bit lets a high-to-low transition set status; resets to 0.
// RULE_16: Differential build keeps upper edge enable words read-write but inert.
// RULE_17: A fixed read-only 32-bit version word is provided.
// RULE_18: With high pull-up, software drives high by disabling, low by enabling with 0.
// RULE_19: Enabled lines drive their bit of the 64-bit output register, reset 0.
// RULE_20: Input register returns the sampled line state, with no reset value.
// RULE_21: Registers sit at fixed offsets, status at 0x18, version at 0xfc.
// RULE_22: Inputs are synchronised before edge detection; both enables catch either edge.
// RULE_23: An edge in the same cycle as its acknowledge keeps the bit set.
module eiop_top
  import eiop_pkg::*;
#(
  parameter int LINES = `EIOP_LINES,
  parameter bit DIFF_BUILD = 1'b0,
  parameter logic [31:0] VERSION = 32'h0000_0001 // Arbitrary value
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic ce,
  input wire eiop_req_t reg_req,
  output logic [31:0] reg_rdata,
  output logic reg_rvalid,
  input wire logic [LINES-1:0] io_in,
  output logic [LINES-1:0] io_out,
  output logic [LINES-1:0] io_oe,
  output logic local_irq_n
);

  localparam int HALF = LINES / 2;
  localparam int GAP = `EIOP_GAP_CYC;
  localparam logic [1:0] GAP_LAST = 2'(GAP - 1);
  localparam logic [2:0] LAST_GROUP = 3'(`EIOP_GROUPS - 1);

  // ----------------------------------------
  // Software-visible registers
  // ----------------------------------------
  logic [LINES-1:0] out_reg;
  logic [LINES-1:0] oe_reg;
  logic [LINES-1:0] rise_en;
  logic [LINES-1:0] fall_en;
  logic [LINES-1:0] status;
  logic [LINES-1:0] next_status;

  // Line sampling
  logic [LINES-1:0] in_meta;
  logic [LINES-1:0] in_sync;
  logic [LINES-1:0] in_prev;
  logic [LINES-1:0] edge_hit;
  logic [LINES-1:0] live_mask;
  logic [LINES-1:0] clr_mask;

  // Sequencer
  eiop_seq_t seq;
  logic [2:0] grp_idx;
  logic [1:0] tick;
  logic out_wr;
  logic [`EIOP_GROUPS-1:0] grp_load;

  // Write strobes
  logic wr_out_lo, wr_out_hi, wr_oe_lo, wr_oe_hi;
  logic wr_isr_lo, wr_isr_hi;
  logic wr_rise_lo, wr_rise_hi, wr_fall_lo, wr_fall_hi;

  // ----------------------------------------
  // Address decode
  // ----------------------------------------
  // Full byte-address compare; unmapped writes are dropped
  assign wr_out_lo = reg_req.wr && reg_req.addr == `EIOP_OFS_OUT_LO; // RULE_21
  assign wr_out_hi = reg_req.wr && reg_req.addr == `EIOP_OFS_OUT_HI;
  assign wr_oe_lo = reg_req.wr && reg_req.addr == `EIOP_OFS_OE_LO;
  assign wr_oe_hi = reg_req.wr && reg_req.addr == `EIOP_OFS_OE_HI;
  assign wr_isr_lo = reg_req.wr && reg_req.addr == `EIOP_OFS_ISR_LO; // RULE_21
  assign wr_isr_hi = reg_req.wr && reg_req.addr == `EIOP_OFS_ISR_HI;
  assign wr_rise_lo = reg_req.wr && reg_req.addr == `EIOP_OFS_RISE_LO;
  assign wr_rise_hi = reg_req.wr && reg_req.addr == `EIOP_OFS_RISE_HI;
  assign wr_fall_lo = reg_req.wr && reg_req.addr == `EIOP_OFS_FALL_LO;
  assign wr_fall_hi = reg_req.wr && reg_req.addr == `EIOP_OFS_FALL_HI;

  // Any output or enable write, even with unchanged data
  assign out_wr = wr_out_lo | wr_out_hi | wr_oe_lo | wr_oe_hi; // RULE_08

  // ----------------------------------------
  // Output data and enable shadows
  // ----------------------------------------
  // Upper words stay read-write in every build; masking happens at the pins
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      out_reg <= '0; // RULE_19
      oe_reg <= '0; // RULE_03
    end else if (ce) begin
      if (wr_out_lo) out_reg[HALF-1:0] <= reg_req.wdata;
      if (wr_out_hi) out_reg[LINES-1:HALF] <= reg_req.wdata;
      if (wr_oe_lo) oe_reg[HALF-1:0] <= reg_req.wdata;
      if (wr_oe_hi) oe_reg[LINES-1:HALF] <= reg_req.wdata; // RULE_04
    end
  end

  // ----------------------------------------
  // Edge enables
  // ----------------------------------------
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      rise_en <= '0; // RULE_14
      fall_en <= '0; // RULE_15
    end else if (ce) begin
      if (wr_rise_lo) rise_en[HALF-1:0] <= reg_req.wdata;
      if (wr_rise_hi) rise_en[LINES-1:HALF] <= reg_req.wdata; // RULE_16
      if (wr_fall_lo) fall_en[HALF-1:0] <= reg_req.wdata;
      if (wr_fall_hi) fall_en[LINES-1:HALF] <= reg_req.wdata; // RULE_16
    end
  end

  // ----------------------------------------
  // Input sampling
  // ----------------------------------------
  // Two flops against metastability, a third holds the previous sample
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      in_meta <= '0;
      in_sync <= '0;
      in_prev <= '0;
    end else if (ce) begin
      in_meta <= io_in; // RULE_02
      in_sync <= in_meta; // RULE_22
      in_prev <= in_sync;
    end
  end

  // Lines beyond the differential width have no function
  assign live_mask = DIFF_BUILD ? {{HALF{1'b0}}, {HALF{1'b1}}} : '1; // RULE_06

  // Either edge counts when both enables are set
  assign edge_hit = live_mask & ((in_sync & ~in_prev & rise_en) // RULE_14
                               | (~in_sync & in_prev & fall_en)); // RULE_15

  // ----------------------------------------
  // Interrupt status
  // ----------------------------------------
  assign clr_mask = {wr_isr_hi ? reg_req.wdata : 32'h0, wr_isr_lo ? reg_req.wdata : 32'h0};

  // Set wins over clear so a coincident event is never lost
  assign next_status = ((status & ~clr_mask) | edge_hit) & live_mask; // RULE_10 RULE_23 RULE_13

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      status <= '0; // RULE_09
    end else if (ce) begin
      status <= next_status; // RULE_09
    end
  end

  // One merged active-low level; a cycle of latency keeps it glitch free
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      local_irq_n <= 1'b1;
    end else if (ce) begin
      local_irq_n <= ~|status; // RULE_11 RULE_12
    end
  end

  // ----------------------------------------
  // Staggered output update
  // ----------------------------------------
  // Spreading the switching limits ground bounce; a new write restarts at group 0
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      seq <= EIOP_IDLE;
      grp_idx <= 3'h0;
      tick <= 2'h0;
    end else if (ce) begin
      if (out_wr) begin
        seq <= EIOP_RUN; // RULE_08
        grp_idx <= 3'h0;
        tick <= 2'h0;
      end else begin
        case (seq)
          EIOP_IDLE: begin
            tick <= 2'h0;
          end
          EIOP_RUN: begin
            if (tick != 2'h0) begin
              tick <= tick - 2'h1;
            end else if (grp_idx == LAST_GROUP) begin
              seq <= EIOP_IDLE;
            end else begin
              grp_idx <= grp_idx + 3'h1; // RULE_07
              tick <= GAP_LAST;
            end
          end
          default: begin
            seq <= EIOP_IDLE;
          end
        endcase
      end
    end
  end

  // ----------------------------------------
  // Line groups driving the pins
  // ----------------------------------------
  genvar g;
  generate
    for (g = 0; g < `EIOP_GROUPS; g++) begin : gen_grp
      localparam int LO = g * `EIOP_GROUP_W;
      assign grp_load[g] = (seq == EIOP_RUN) && !out_wr && tick == 2'h0 && grp_idx == 3'(g); // RULE_07
      eiop_line_group #(.W(`EIOP_GROUP_W)) u_grp (
        .clk(clk),
        .rst(rst),
        .ce(ce),
        .load(grp_load[g]),
        .din(out_reg[LO +: `EIOP_GROUP_W]), // RULE_19
        .oein(oe_reg[LO +: `EIOP_GROUP_W] & live_mask[LO +: `EIOP_GROUP_W]), // RULE_03 RULE_05
        .dout(io_out[LO +: `EIOP_GROUP_W]),
        .oe(io_oe[LO +: `EIOP_GROUP_W]) // RULE_01
      );
    end
  endgenerate

  // ----------------------------------------
  // Read path
  // ----------------------------------------
  // Data answers one cycle after the read strobe; unmapped offsets read 0
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      reg_rdata <= 32'h0;
      reg_rvalid <= 1'b0;
    end else if (ce) begin
      reg_rvalid <= reg_req.rd;
      case (reg_req.addr)
        `EIOP_OFS_OUT_LO: reg_rdata <= out_reg[HALF-1:0];
        `EIOP_OFS_OUT_HI: reg_rdata <= out_reg[LINES-1:HALF];
        `EIOP_OFS_IN_LO: reg_rdata <= in_sync[HALF-1:0]; // RULE_20
        `EIOP_OFS_IN_HI: reg_rdata <= in_sync[LINES-1:HALF] & live_mask[LINES-1:HALF]; // RULE_13
        `EIOP_OFS_OE_LO: reg_rdata <= oe_reg[HALF-1:0];
        `EIOP_OFS_OE_HI: reg_rdata <= oe_reg[LINES-1:HALF]; // RULE_04
        `EIOP_OFS_ISR_LO: reg_rdata <= status[HALF-1:0];
        `EIOP_OFS_ISR_HI: reg_rdata <= status[LINES-1:HALF]; // RULE_13
        `EIOP_OFS_RISE_LO: reg_rdata <= rise_en[HALF-1:0];
        `EIOP_OFS_RISE_HI: reg_rdata <= rise_en[LINES-1:HALF];
        `EIOP_OFS_FALL_LO: reg_rdata <= fall_en[HALF-1:0];
        `EIOP_OFS_FALL_HI: reg_rdata <= fall_en[LINES-1:HALF];
        `EIOP_OFS_VERSION: reg_rdata <= VERSION; // RULE_17
        default: reg_rdata <= `EIOP_RST_WORD;
      endcase
    end
  end

  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  sequence s_group_due;
    ce && seq == EIOP_RUN && !out_wr && tick == 2'h0;
  endsequence

  sequence s_next_group;
    ce && !out_wr;
  endsequence

  property p_irq_level;
    @(posedge clk) disable iff (rst) ce |=> local_irq_n == !$past(|status);
  endproperty
  a_irq_level: assert property (p_irq_level) else $error("irq level wrong"); // RULE_12

  property p_w1c;
    @(posedge clk) disable iff (rst) ce |=> (status & $past(clr_mask) & ~$past(edge_hit)) == '0;
  endproperty
  a_w1c: assert property (p_w1c) else $error("status not cleared"); // RULE_10

  property p_hold;
    @(posedge clk) disable iff (rst) ce |=> ($past(status) & ~$past(clr_mask) & ~status) == '0;
  endproperty
  a_hold: assert property (p_hold) else $error("status lost"); // RULE_10

  property p_set;
    @(posedge clk) disable iff (rst) ce |=> ($past(edge_hit) & ~status) == '0;
  endproperty
  a_set: assert property (p_set) else $error("event lost"); // RULE_23

  property p_only_enabled;
    @(posedge clk) disable iff (rst) ce |=> (status & ~$past(status) & ~$past(edge_hit)) == '0;
  endproperty
  a_only_enabled: assert property (p_only_enabled) else $error("spurious status"); // RULE_09

  property p_upper_zero;
    @(posedge clk) disable iff (rst) DIFF_BUILD |-> status[LINES-1:HALF] == '0 && io_oe[LINES-1:HALF] == '0;
  endproperty
  a_upper_zero: assert property (p_upper_zero) else $error("upper half active"); // RULE_13

  property p_seq_start;
    @(posedge clk) disable iff (rst) ce && out_wr |=> seq == EIOP_RUN && grp_idx == 3'h0 && tick == 2'h0;
  endproperty
  a_seq_start: assert property (p_seq_start) else $error("update not started"); // RULE_08

  property p_seq_step;
    @(posedge clk) disable iff (rst)
      s_group_due ##0 (grp_idx != LAST_GROUP) ##1 s_next_group |-> grp_idx == $past(grp_idx) + 3'h1 && tick == GAP_LAST;
  endproperty
  a_seq_step: assert property (p_seq_step) else $error("group step wrong"); // RULE_07

  property p_settled;
    @(posedge clk) disable iff (rst) seq == EIOP_IDLE |-> io_oe == (oe_reg & live_mask) && io_out == out_reg;
  endproperty
  a_settled: assert property (p_settled) else $error("pins differ from registers"); // RULE_03

endmodule

// ===== verif/edge_interrupt_io_port_tb_top.sv
`timescale 1ns/1ns
`include "eiop_cfg.svh"
module edge_interrupt_io_port_tb_top
  import eiop_pkg::*;
;
  localparam logic [31:0] VER = 32'h0000_00a5; // Arbitrary value
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic ce = 1'b1;
  eiop_req_t req = '0;
  logic [31:0] rdata, rdata2, d, r, f, st, ex;
  logic rvalid, irq_n;
  logic [63:0] io_in, io_out, io_oe, io_oe2, sh_out, sh_oe, pin_out, pin_oe;
  logic [63:0] ext_en = '0;
  logic [63:0] ext_val = '0;
  logic [7:0] rw_ofs [8] = '{8'h00, 8'h04, 8'h10, 8'h14, 8'h20, 8'h24, 8'h28, 8'h2c};
  logic [7:0] stg_ofs [4] = '{8'h10, 8'h14, 8'h00, 8'h04};
  int err_count = 0;
  int checks_done = 0;

  eiop_top #(.LINES(64), .DIFF_BUILD(1'b0), .VERSION(VER)) dut (
    .clk(clk), .rst(rst), .ce(ce), .reg_req(req), .reg_rdata(rdata), .reg_rvalid(rvalid),
    .io_in(io_in), .io_out(io_out), .io_oe(io_oe), .local_irq_n(irq_n));
  // Differential build on the same bus and lines; only its read data and enables are watched
  eiop_top #(.LINES(64), .DIFF_BUILD(1'b1), .VERSION(VER)) dut_diff (
    .clk(clk), .rst(rst), .ce(ce), .reg_req(req), .reg_rdata(rdata2), .reg_rvalid(),
    .io_in(io_in), .io_out(), .io_oe(io_oe2), .local_irq_n());
  eiop_line_model #(.N(64)) lines (
    .io_out(io_out), .io_oe(io_oe), .ext_en(ext_en), .ext_val(ext_val), .line(io_in));

  always #4 clk = ~clk;

  // ----------------------------------------
  // Bus tasks and checking
  // ----------------------------------------
  task automatic report_and_stop();
    if (err_count == 0 && checks_done > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  task automatic check(input string what, input logic [63:0] seen, input logic [63:0] exp);
    checks_done++;
    if (seen !== exp) begin
      err_count++;
      $display("BAD %s expected %h seen %h", what, exp, seen);
    end
  endtask

  // Strobe lasts one cycle; address stays put since read data tracks it
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    @(negedge clk);
    req.wr = 1'b1;
    req.addr = a;
    req.wdata = v;
    @(negedge clk);
    req.wr = 1'b0;
  endtask

  task automatic rdchk(input string what, input logic [7:0] a, input logic [31:0] exp);
    @(negedge clk);
    req.rd = 1'b1;
    req.addr = a;
    @(negedge clk);
    // The answer stands for one cycle only, so it is taken before the strobe drops
    check("rvalid", {63'h0, rvalid}, 64'h1);
    check(what, {32'h0, rdata}, {32'h0, exp});
    req.rd = 1'b0;
  endtask

  // Group g takes its shadow value two cycles apart, first one on the edge after the write
  function automatic logic [63:0] staged(input logic [63:0] o, input logic [63:0] n, input int k);
    for (int g = 0; g < 8; g++) begin
      if (2 * g + 1 <= k) o[8*g +: 8] = n[8*g +: 8];
    end
    return o;
  endfunction

  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  initial begin
    void'($urandom(15));
    repeat (6) @(negedge clk);
    rst = 1'b0;
    // Reset values; undriven lines read high through the pull-ups, 0x30 is unmapped
    for (int a = 0; a < 8'h34; a += 4) begin
      ex = (a == 8 || a == 12) ? 32'hffff_ffff : 32'h0;
      rdchk("reset", a[7:0], ex);
    end
    rdchk("version", `EIOP_OFS_VERSION, VER);
    check("irq idle", {63'h0, irq_n}, 64'h1);
    // Far end drives every line
    ext_val = {$urandom, $urandom};
    ext_en = '1;
    repeat (4) @(negedge clk);
    rdchk("in lo", `EIOP_OFS_IN_LO, ext_val[31:0]);
    rdchk("in hi", `EIOP_OFS_IN_HI, ext_val[63:32]);
    check("diff in hi", {32'h0, rdata2}, 64'h0);
    ext_en = '0;
    // Read-write words, cleared again so no edges stay armed
    foreach (rw_ofs[i]) begin
      d = (i == 0) ? 32'hffff_ffff : $urandom;
      wr(rw_ofs[i], d);
      rdchk("rw", rw_ofs[i], d);
      check("diff rw", {32'h0, rdata2}, {32'h0, d});
      wr(rw_ofs[i], 32'h0);
    end
    // Staggered update of enables then data, every group timed
    sh_out = '0;
    sh_oe = '0;
    pin_out = '0;
    pin_oe = '0;
    for (int i = 0; i < 4; i++) begin
      d = $urandom;
      if (i < 2) sh_oe[32*(i%2) +: 32] = d;
      else sh_out[32*(i%2) +: 32] = d;
      wr(stg_ofs[i], d);
      for (int k = 0; k < 18; k++) begin
        check("io_out", io_out, staged(pin_out, sh_out, k));
        check("io_oe", io_oe, staged(pin_oe, sh_oe, k));
        @(negedge clk);
      end
      pin_out = sh_out;
      pin_oe = sh_oe;
    end
    // Differential build gates the low transmitters and never enables the upper word
    check("diff io_oe", io_oe2, {32'h0, sh_oe[31:0]});
    ex = sh_out[31:0] | ~sh_oe[31:0];
    rdchk("readback", `EIOP_OFS_IN_LO, ex);
    ex = sh_out[63:32] | ~sh_oe[63:32];
    rdchk("readback", `EIOP_OFS_IN_HI, ex);
    // Edge interrupts on the low word, lines driven by the port itself
    wr(`EIOP_OFS_OE_LO, 32'hffff_ffff);
    wr(`EIOP_OFS_OUT_LO, 32'h0);
    repeat (20) @(negedge clk);
    wr(`EIOP_OFS_ISR_LO, 32'hffff_ffff);
    wr(`EIOP_OFS_ISR_HI, 32'hffff_ffff);
    r = $urandom;
    f = $urandom;
    d = $urandom;
    wr(`EIOP_OFS_RISE_LO, r);
    wr(`EIOP_OFS_FALL_LO, f);
    wr(`EIOP_OFS_OUT_LO, d);
    repeat (25) @(negedge clk);
    st = d & r;
    rdchk("rise status", `EIOP_OFS_ISR_LO, st);
    check("irq", {63'h0, irq_n}, {63'h0, st == 32'h0});
    wr(`EIOP_OFS_OUT_LO, 32'h0);
    repeat (25) @(negedge clk);
    st = st | (d & f);
    rdchk("fall status", `EIOP_OFS_ISR_LO, st);
    rdchk("upper status", `EIOP_OFS_ISR_HI, 32'h0);
    d = $urandom;
    wr(`EIOP_OFS_ISR_LO, d);
    st = st & ~d;
    rdchk("partial ack", `EIOP_OFS_ISR_LO, st);
    check("irq held", {63'h0, irq_n}, {63'h0, st == 32'h0});
    wr(`EIOP_OFS_ISR_LO, 32'hffff_ffff);
    repeat (3) @(negedge clk);
    check("irq released", {63'h0, irq_n}, 64'h1);
    rdchk("cleared", `EIOP_OFS_ISR_LO, 32'h0);
    // A write while the clock enable is low must leave no trace
    ce = 1'b0;
    wr(`EIOP_OFS_OUT_LO, 32'hffff_ffff);
    ce = 1'b1;
    rdchk("ce freeze", `EIOP_OFS_OUT_LO, 32'h0);
    report_and_stop();
  end

  // Whole run is under three hundred cycles; this bound only cuts a hang
  initial begin
    #300000;
    err_count++;
    report_and_stop();
  end
endmodule

// ===== verif/eiop_line_model.sv
`timescale 1ns/1ns
// ----------------------------------------
// External lines: pull-ups and a far-end driver
// ----------------------------------------
module eiop_line_model #(
  parameter int N = 64
) (
  input wire logic [N-1:0] io_out,
  input wire logic [N-1:0] io_oe,
  input wire logic [N-1:0] ext_en,
  input wire logic [N-1:0] ext_val,
  output logic [N-1:0] line
);
  // Port-driven lines win, then the far-end driver; a line neither drives goes to the pull-up, never to stale data
  always_comb begin
    for (int i = 0; i < N; i++) begin
      line[i] = io_oe[i] ? io_out[i] : (ext_en[i] ? ext_val[i] : 1'b1);
    end
  end
endmodule
